// ### sci_cmd.sv
// serial command-state interpreter with wishbone status registers
module sci_cmd #(
	parameter int TICK_CYCLES_P = sci_pkg::TICK_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire sci_pkg::sci_wb_req_t wb_req,
	output sci_pkg::sci_wb_rsp_t wb_rsp,
	input wire sci_pkg::sci_char_t rx_i,
	input wire logic tx_ready,
	input wire logic pay_busy,
	output sci_pkg::sci_char_t pay_o,
	output logic flush_o,
	output sci_pkg::sci_char_t tx_o,
	output sci_pkg::sci_cfg_t cfg_o,
	output logic in_cmd
);
	import sci_pkg::*;

	localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES_P - 1);

	sci_st_t st_ff;
	sci_st_t nxt_st;
	logic do_apply;
	logic [15:0] nv_rdata;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] nib2hex(input logic [3:0] n);
		return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
	endfunction

	function automatic logic [4:0] hex2nib(input logic [7:0] c);
		if (c >= 8'h30 && c <= 8'h39) return {1'b1, 4'(c - 8'h30)};
		if (c >= 8'h41 && c <= 8'h46) return {1'b1, 4'(c - 8'h37)};
		if (c >= 8'h61 && c <= 8'h66) return {1'b1, 4'(c - 8'h57)};
		return 5'h00;
	endfunction

	// {last, char} of reply character idx
	function automatic logic [8:0] rpl_char(input sci_rpl_t k,
			input logic [2:0] idx, input logic [15:0] v);
		unique case (k)
		RPL_OK: return {idx == 3'h2, MSG_OK[8 * (2 - int'(idx)) +: 8]};
		RPL_ERR: return {idx == 3'h5, MSG_ERR[8 * (5 - int'(idx)) +: 8]};
		RPL_VAL: begin
			if (idx == 3'h4) return {1'b1, CH_CR};
			return {1'b0, nib2hex(v[4 * (3 - int'(idx)) +: 4])};
		end
		default: return 9'h000;
		endcase
	endfunction

	// {known, index} of a setting command
	function automatic logic [2:0] set_idx(input logic [15:0] code);
		unique case (code)
		CMD_BAUD: return {1'b1, IDX_BAUD};
		CMD_GUARD: return {1'b1, IDX_GUARD};
		CMD_ESC: return {1'b1, IDX_ESC};
		CMD_TMO: return {1'b1, IDX_TMO};
		default: return 3'h0;
		endcase
	endfunction

	// ------------------------------------------------------------
	// settings store
	// ------------------------------------------------------------
	sci_nvm u_nvm (
		.clk(clk),
		.ce(ce),
		.we(st_ff.sv != 3'h0),
		.waddr(2'(st_ff.sv - 3'h1)),
		.wdata(st_ff.pend[2'(st_ff.sv - 3'h1)]),
		.raddr(st_ff.ld[1:0]),
		.rdata(nv_rdata)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic tick_hit;
		logic guard_ok;
		logic esc_hit;
		logic [8:0] rc;
		logic [4:0] hn;
		logic [2:0] si;
		tick_hit = st_ff.tick == TICK_LAST;
		guard_ok = st_ff.silence >= st_ff.act[IDX_GUARD];
		esc_hit = rx_i.vld && rx_i.dat == st_ff.act[IDX_ESC][7:0];
		hn = hex2nib(rx_i.dat);
		si = set_idx(st_ff.code);
		rc = rpl_char(st_ff.rpl, st_ff.ridx, st_ff.rval);
		do_apply = 1'b0;
		nxt_st = st_ff;
		nxt_st.pay.vld = 1'b0;
		nxt_st.tx.vld = 1'b0;
		nxt_st.flush = 1'b0;
		nxt_st.tick = tick_hit ? 17'h0 : st_ff.tick + 17'h1;
		if (rx_i.vld) begin
			nxt_st.silence = 16'h0;
		end else if (tick_hit && st_ff.silence != 16'hffff) begin
			nxt_st.silence = st_ff.silence + 16'h1;
		end
		if (tick_hit && st_ff.state == S_CMD) begin
			nxt_st.cmd_ms = st_ff.cmd_ms + 24'h1;
		end

		// ack one cycle after request; a write lands as the master sees ack
		nxt_st.wb.ack = wb_req.cyc && wb_req.stb && !st_ff.wb.ack;
		nxt_st.wb.dat = 32'h0;
		if (st_ff.wb.ack && wb_req.cyc && wb_req.stb && wb_req.we
				&& wb_req.adr == REG_CTRL && wb_req.sel[0]) begin
			nxt_st.esc_en = wb_req.dat[CTRL_ESC_EN_BIT];
		end
		if (nxt_st.wb.ack && !wb_req.we) begin
			unique case (wb_req.adr)
			REG_STATUS: begin
				nxt_st.wb.dat[STS_IN_CMD_BIT] = st_ff.state == S_CMD;
				nxt_st.wb.dat[STS_PEND_BIT] = st_ff.pend != st_ff.act;
				nxt_st.wb.dat[STS_SAVE_BIT] = st_ff.sv != 3'h0;
			end
			REG_CTRL: nxt_st.wb.dat[CTRL_ESC_EN_BIT] = st_ff.esc_en;
			REG_BAUD: nxt_st.wb.dat[15:0] = st_ff.act[IDX_BAUD];
			REG_GUARD: nxt_st.wb.dat[15:0] = st_ff.act[IDX_GUARD];
			REG_ESC: nxt_st.wb.dat[15:0] = st_ff.act[IDX_ESC];
			REG_TMO: nxt_st.wb.dat[15:0] = st_ff.act[IDX_TMO];
			default: nxt_st.wb.dat = 32'h0;
			endcase
		end

		// reply waits for earlier payload to drain
		if (st_ff.rpl != RPL_NONE && !pay_busy && tx_ready
				&& !st_ff.tx.vld) begin
			nxt_st.tx = {1'b1, rc[7:0]};
			nxt_st.ridx = rc[8] ? 3'h0 : st_ff.ridx + 3'h1;
			nxt_st.rpl = rc[8] ? RPL_NONE : st_ff.rpl;
		end
		if (st_ff.sv != 3'h0) begin
			nxt_st.sv = (st_ff.sv == 3'h4) ? 3'h0 : st_ff.sv + 3'h1;
		end

		unique case (st_ff.state)
		S_LOAD: begin
			// store read data lags its address by one cycle
			if (st_ff.ld != 3'h0) begin
				nxt_st.act[2'(st_ff.ld - 3'h1)] = nv_rdata;
				nxt_st.pend[2'(st_ff.ld - 3'h1)] = nv_rdata;
			end
			nxt_st.ld = st_ff.ld + 3'h1;
			if (st_ff.ld == 3'h4) begin
				nxt_st.ld = 3'h0;
				nxt_st.state = S_DATA;
			end
		end
		S_DATA: begin
			// only the uart stream is watched for the pattern
			if (esc_hit && st_ff.esc_en && guard_ok && st_ff.emit == 2'h0
					&& !st_ff.hold_vld) begin
				nxt_st.plus = 2'h1;
				nxt_st.state = S_ESC;
			end else if (rx_i.vld) begin
				nxt_st.pay = rx_i;
			end else if (st_ff.emit != 2'h0) begin
				nxt_st.pay = {1'b1, st_ff.act[IDX_ESC][7:0]};
				nxt_st.emit = st_ff.emit - 2'h1;
			end else if (st_ff.hold_vld) begin
				nxt_st.pay = {1'b1, st_ff.hold};
				nxt_st.hold_vld = 1'b0;
			end
		end
		S_ESC: begin
			if (esc_hit) begin
				nxt_st.plus = st_ff.plus + 2'h1;
				if (st_ff.plus == 2'h2) begin
					nxt_st.state = S_GUARD;
				end
			end else if (rx_i.vld || guard_ok) begin
				// not a pattern: the held escape chars become payload
				nxt_st.emit = st_ff.plus;
				nxt_st.hold = rx_i.dat;
				nxt_st.hold_vld = rx_i.vld;
				nxt_st.state = S_DATA;
			end
		end
		S_GUARD: begin
			if (rx_i.vld) begin
				nxt_st.emit = 2'h3;
				nxt_st.hold = rx_i.dat;
				nxt_st.hold_vld = 1'b1;
				nxt_st.state = S_DATA;
			end else if (guard_ok) begin
				nxt_st.state = S_CMD;
				nxt_st.flush = 1'b1;
				nxt_st.rpl = RPL_OK;
				nxt_st.ridx = 3'h0;
				nxt_st.cmd_ms = 24'h0;
				nxt_st.pos = 4'h0;
				nxt_st.perr = 1'b0;
				nxt_st.param = 16'h0;
			end
		end
		S_CMD: begin
			if (rx_i.vld && rx_i.dat == CH_CR) begin
				nxt_st.pos = 4'h0;
				nxt_st.perr = 1'b0;
				nxt_st.param = 16'h0;
				if (st_ff.pos != 4'h0) begin
					nxt_st.cmd_ms = 24'h0;
					nxt_st.ridx = 3'h0;
					nxt_st.rpl = RPL_ERR;
					if (!st_ff.perr && st_ff.pos >= 4'h4) begin
						unique case (st_ff.code)
						CMD_APPLY: begin
							do_apply = 1'b1;
							nxt_st.act = st_ff.pend;
							nxt_st.rpl = RPL_OK;
						end
						CMD_LEAVE: begin
							do_apply = 1'b1;
							nxt_st.act = st_ff.pend;
							nxt_st.state = S_DATA;
							nxt_st.rpl = RPL_OK;
						end
						CMD_SAVE: begin
							nxt_st.sv = 3'h1;
							nxt_st.rpl = RPL_OK;
						end
						default: begin
							if (si[2] && st_ff.pos == 4'h4) begin
								nxt_st.rpl = RPL_VAL;
								nxt_st.rval = st_ff.pend[si[1:0]];
							end else if (si[2] && !(si[1:0] == IDX_BAUD
									&& st_ff.param > BAUD_MAX)) begin
								nxt_st.pend[si[1:0]] = st_ff.param;
								nxt_st.rpl = RPL_OK;
							end
						end
						endcase
					end
				end
			end else if (rx_i.vld) begin
				if (st_ff.pos != 4'hf) begin
					nxt_st.pos = st_ff.pos + 4'h1;
				end
				unique case (st_ff.pos)
				4'h0: nxt_st.perr = st_ff.perr || rx_i.dat != CH_A;
				4'h1: nxt_st.perr = st_ff.perr || rx_i.dat != CH_T;
				4'h2, 4'h3: nxt_st.code = {st_ff.code[7:0], rx_i.dat};
				default: begin
					nxt_st.perr = st_ff.perr || !hn[4] || st_ff.pos > 4'h7;
					nxt_st.param = {st_ff.param[11:0], hn[3:0]};
				end
				endcase
			end else if (st_ff.cmd_ms
					>= 24'(st_ff.act[IDX_TMO] * TMO_UNIT_MS)) begin
				do_apply = 1'b1;
				nxt_st.act = st_ff.pend;
				nxt_st.state = S_DATA;
			end
		end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_ff <= ST_RST;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	assign wb_rsp = st_ff.wb;
	assign pay_o = st_ff.pay;
	assign flush_o = st_ff.flush;
	assign tx_o = st_ff.tx;
	assign cfg_o = st_ff.act;
	assign in_cmd = st_ff.state[4];

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n || !ce);

	esc_accept_a: assert property (
		(st_ff.state == S_GUARD && !rx_i.vld
			&& st_ff.silence >= st_ff.act[IDX_GUARD])
		|=> st_ff.state == S_CMD && st_ff.flush)
		else $error("guard silence did not enter command state");
	esc_cancel_a: assert property (
		(st_ff.state == S_GUARD && rx_i.vld)
		|=> st_ff.state == S_DATA && st_ff.emit == 2'h3)
		else $error("extra char did not cancel entry");
	no_forward_a: assert property (
		st_ff.state == S_CMD |-> !st_ff.pay.vld)
		else $error("payload forwarded in command state");
	entry_ok_a: assert property (
		(st_ff.state == S_GUARD ##1 st_ff.state == S_CMD)
		|-> st_ff.rpl == RPL_OK && !st_ff.pay.vld)
		else $error("no ok queued on entry");
	tx_hold_a: assert property (
		pay_busy |=> !st_ff.tx.vld)
		else $error("reply sent while payload busy");
	timeout_exit_a: assert property (
		(st_ff.state == S_CMD && !rx_i.vld && st_ff.cmd_ms
			>= 24'(st_ff.act[IDX_TMO] * TMO_UNIT_MS))
		|=> st_ff.state == S_DATA)
		else $error("command timeout ignored");
	pend_held_a: assert property (
		(st_ff.state != S_LOAD && !do_apply) |=> $stable(st_ff.act))
		else $error("setting took effect without apply");
	exit_apply_a: assert property (
		(st_ff.state == S_CMD ##1 st_ff.state == S_DATA)
		|-> st_ff.act == $past(st_ff.pend))
		else $error("leaving did not apply pending values");
	save_walk_a: assert property (
		$rose(st_ff.sv != 3'h0) |-> (st_ff.sv != 3'h0)[*4] ##1 st_ff.sv == 3'h0)
		else $error("save did not write four words");
	cr_reply_a: assert property (
		(st_ff.state == S_CMD && rx_i.vld && rx_i.dat == CH_CR
			&& st_ff.pos != 4'h0)
		|=> st_ff.rpl != RPL_NONE && st_ff.cmd_ms == 24'h0)
		else $error("terminated line not answered");

	enter_c: cover property (st_ff.state == S_GUARD ##1 st_ff.state == S_CMD);
	read_c: cover property (st_ff.rpl == RPL_VAL);
	save_c: cover property ($rose(st_ff.sv != 3'h0));
	tmo_c: cover property (st_ff.state == S_CMD && !rx_i.vld
		&& st_ff.cmd_ms >= 24'(st_ff.act[IDX_TMO] * TMO_UNIT_MS));
endmodule // sci_cmd

// ### sci_host_model.sv
// host-side partner model: sends uart characters, collects replies and payload
module sci_host_model (
	input wire logic clk,
	input wire logic slow,
	output sci_pkg::sci_char_t rx_o,
	output logic tx_ready,
	input wire sci_pkg::sci_char_t tx_i,
	input wire sci_pkg::sci_char_t pay_i
);
	timeunit 1ns;
	timeprecision 1ps;
	import sci_pkg::*;

	logic [7:0] reply_q[$];
	logic [7:0] pay_q[$];

	initial begin
		rx_o = '0;
		tx_ready = 1'b1;
	end

	// ------------------------------------------------------------
	// receive side
	// ------------------------------------------------------------
	// slow mode takes a reply char only every other cycle
	always @(posedge clk) begin
		if (tx_i.vld === 1'b1)
			reply_q.push_back(tx_i.dat);
		if (pay_i.vld === 1'b1)
			pay_q.push_back(pay_i.dat);
		tx_ready <= slow ? ~tx_ready : 1'b1;
	end

	// ------------------------------------------------------------
	// send side
	// ------------------------------------------------------------
	// idle line shows the inverse, so a stale char is never mistaken
	task automatic send_char(input logic [7:0] ch);
		@(posedge clk);
		rx_o <= '{vld: 1'b1, dat: ch};
		@(posedge clk);
		rx_o <= '{vld: 1'b0, dat: ~ch};
		repeat (14) @(posedge clk);
	endtask

	// lines are given whole, AT prefix and CR included
	task automatic send_str(input string s);
		for (int i = 0; i < s.len(); i++) begin
			send_char(s[i]);
		end
	endtask
endmodule // sci_host_model

// ### sci_nvm.sv
// settings store that keeps its contents across reset
module sci_nvm (
	input wire logic clk,
	input wire logic ce,
	input wire logic we,
	input wire logic [1:0] waddr,
	input wire logic [15:0] wdata,
	input wire logic [1:0] raddr,
	output logic [15:0] rdata
);
	import sci_pkg::*;

	logic [15:0] mem [0:3];

	// factory contents; deliberately untouched by rst_n
	initial begin
		for (int i = 0; i < 4; i++) begin
			mem[i] = CFG_RST[i];
		end
	end

	always_ff @(posedge clk) begin
		if (ce) begin
			if (we) begin
				mem[waddr] <= wdata;
			end
			rdata <= mem[raddr];
		end
	end
endmodule // sci_nvm

// ### sci_pkg.sv
// package of constants and types for the serial command-state interpreter
package sci_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 125_000_000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
	localparam int GUARD_TIME_MS = 1000;
	localparam int CMD_TIMEOUT_S = 10;
	localparam int TMO_UNIT_MS = 100;

	// ------------------------------------------------------------
	// settings: index and reset value
	// ------------------------------------------------------------
	localparam logic [1:0] IDX_BAUD = 2'h0;
	localparam logic [1:0] IDX_GUARD = 2'h1;
	localparam logic [1:0] IDX_ESC = 2'h2;
	localparam logic [1:0] IDX_TMO = 2'h3;
	localparam logic [15:0] BAUD_RST = 16'h0003;
	localparam logic [15:0] BAUD_MAX = 16'h0007;
	localparam logic [15:0] GUARD_RST = 16'(GUARD_TIME_MS);
	localparam logic [15:0] ESC_RST = 16'h002b;
	localparam logic [15:0] TMO_RST = 16'(CMD_TIMEOUT_S * 1000 / TMO_UNIT_MS);
	typedef logic [3:0][15:0] sci_cfg_t;
	localparam sci_cfg_t CFG_RST = {TMO_RST, ESC_RST, GUARD_RST, BAUD_RST};

	// ------------------------------------------------------------
	// characters, commands and replies
	// ------------------------------------------------------------
	localparam logic [7:0] CH_A = 8'h41;
	localparam logic [7:0] CH_T = 8'h54;
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [15:0] CMD_BAUD = 16'h4244;
	localparam logic [15:0] CMD_GUARD = 16'h4754;
	localparam logic [15:0] CMD_ESC = 16'h4343;
	localparam logic [15:0] CMD_TMO = 16'h4354;
	localparam logic [15:0] CMD_APPLY = 16'h4143;
	localparam logic [15:0] CMD_LEAVE = 16'h434e;
	localparam logic [15:0] CMD_SAVE = 16'h5752;
	localparam logic [23:0] MSG_OK = 24'h4f4b0d;
	localparam logic [47:0] MSG_ERR = 48'h4552524f520d;
	typedef enum logic [1:0] {
		RPL_NONE = 2'h0,
		RPL_OK = 2'h1,
		RPL_ERR = 2'h2,
		RPL_VAL = 2'h3
	} sci_rpl_t;

	// ------------------------------------------------------------
	// register map (byte offsets) and fields
	// ------------------------------------------------------------
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_CTRL = 8'h04;
	localparam logic [7:0] REG_BAUD = 8'h08;
	localparam logic [7:0] REG_GUARD = 8'h0c;
	localparam logic [7:0] REG_ESC = 8'h10;
	localparam logic [7:0] REG_TMO = 8'h14;
	localparam int STS_IN_CMD_BIT = 0;
	localparam int STS_PEND_BIT = 1;
	localparam int STS_SAVE_BIT = 2;
	localparam int CTRL_ESC_EN_BIT = 0;
	localparam logic CTRL_ESC_EN_RST = 1'b1;

	// ------------------------------------------------------------
	// carriers and state
	// ------------------------------------------------------------
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} sci_wb_req_t;
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} sci_wb_rsp_t;
	typedef struct packed {
		logic vld;
		logic [7:0] dat;
	} sci_char_t;
	typedef enum logic [4:0] {
		S_LOAD = 5'h01,
		S_DATA = 5'h02,
		S_ESC = 5'h04,
		S_GUARD = 5'h08,
		S_CMD = 5'h10
	} sci_state_t;
	typedef struct packed {
		sci_state_t state;
		logic [16:0] tick;
		logic [15:0] silence;
		logic [23:0] cmd_ms;
		logic [1:0] plus;
		logic [1:0] emit;
		logic hold_vld;
		logic [7:0] hold;
		logic [3:0] pos;
		logic perr;
		logic [15:0] code;
		logic [15:0] param;
		sci_rpl_t rpl;
		logic [2:0] ridx;
		logic [15:0] rval;
		sci_cfg_t act;
		sci_cfg_t pend;
		logic [2:0] ld;
		logic [2:0] sv;
		logic esc_en;
		sci_char_t pay;
		sci_char_t tx;
		logic flush;
		sci_wb_rsp_t wb;
	} sci_st_t;
	localparam sci_st_t ST_RST = '{state: S_LOAD, rpl: RPL_NONE,
		act: CFG_RST, pend: CFG_RST, esc_en: CTRL_ESC_EN_RST, default: '0};

endpackage

// ### tb.sv
// self-checking testbench of the serial command-state interpreter
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sci_pkg::*;

	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic pay_busy = 1'b0;
	logic slow = 1'b0;
	sci_wb_req_t wb_req = '0;
	sci_wb_rsp_t wb_rsp;
	sci_char_t rx_c, tx_c, pay_c;
	sci_cfg_t cfg_o;
	logic flush_o, in_cmd, tx_ready;
	int err_total = 0;
	int samples_checked = 0;
	int flush_cnt = 0;
	logic [31:0] rd;

	always #4 clk = ~clk;
	// counted mid-cycle so the total is settled before any edge looks at it
	always @(negedge clk) if (flush_o === 1'b1) flush_cnt++;

	// tick of 10 cycles keeps the one-second guard at 10000 cycles
	sci_cmd #(.TICK_CYCLES_P(10)) sci_cmd_inst (
		.clk(clk), .rst_n(rst_n), .ce(ce), .wb_req(wb_req),
		.wb_rsp(wb_rsp), .rx_i(rx_c), .tx_ready(tx_ready),
		.pay_busy(pay_busy), .pay_o(pay_c), .flush_o(flush_o),
		.tx_o(tx_c), .cfg_o(cfg_o), .in_cmd(in_cmd));
	sci_host_model sci_host_model_inst (
		.clk(clk), .slow(slow), .rx_o(rx_c), .tx_ready(tx_ready),
		.tx_i(tx_c), .pay_i(pay_c));

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wb_xfer(input logic we, input logic [7:0] adr,
		input logic [31:0] dat, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf,
			dat: dat};
		do begin
			@(posedge clk);
			n++;
		end while (wb_rsp.ack !== 1'b1 && n < 50);
		q = wb_rsp.dat;
		wb_req <= '0;
		check("wb ack", 32'(wb_rsp.ack), 32'h1);
	endtask

	task automatic expect_chars(ref logic [7:0] q[$], input string s);
		int n;
		logic [7:0] c;
		n = 0;
		while (q.size() < s.len() && n < 3000) begin
			@(posedge clk);
			n++;
		end
		for (int i = 0; i < s.len(); i++) begin
			c = 'x;
			if (q.size() > 0)
				c = q.pop_front();
			check("char", 32'(c), 32'(s[i]));
		end
		check("extra chars", 32'(q.size()), 32'h0);
	endtask

	task automatic wait_cmd(input logic lvl, input int lim);
		int n;
		n = 0;
		while (in_cmd !== lvl && n < lim) begin
			@(posedge clk);
			n++;
		end
		check("in_cmd", 32'(in_cmd), 32'(lvl));
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		check("baud", 32'(cfg_o[IDX_BAUD]), 32'h3);
		check("timeout", 32'(cfg_o[IDX_TMO]), 32'h64);
		wb_xfer(1'b0, REG_BAUD, 32'h0, rd);
		check("baud reg", rd, 32'h3);
		wb_xfer(1'b0, REG_ESC, 32'h0, rd);
		check("esc reg", rd, 32'(ESC_RST));
		wb_xfer(1'b0, 8'h40, 32'h0, rd);
		check("unmapped", rd, 32'h0);
		wb_xfer(1'b0, REG_CTRL, 32'h0, rd);
		check("ctrl", rd, 32'h1);
		$display("test reset done");

		sci_host_model_inst.send_char(8'h78);
		expect_chars(sci_host_model_inst.pay_q, "x");
		pay_busy <= 1'b1;
		repeat (10100) @(posedge clk);
		sci_host_model_inst.send_str("+++");
		repeat (9000) @(posedge clk);
		check("early entry", 32'(in_cmd), 32'h0);
		wait_cmd(1'b1, 1500);
		check("flush", 32'(flush_cnt), 32'h1);
		repeat (40) @(posedge clk);
		check("held reply", 32'(sci_host_model_inst.reply_q.size()),
			32'h0);
		pay_busy <= 1'b0;
		expect_chars(sci_host_model_inst.reply_q, "OK\015");
		$display("test entry done");

		slow <= 1'b1;
		sci_host_model_inst.send_str("ATBD5\015");
		expect_chars(sci_host_model_inst.reply_q, "OK\015");
		check("baud pending", 32'(cfg_o[IDX_BAUD]), 32'h3);
		wb_xfer(1'b0, REG_STATUS, 32'h0, rd);
		check("status", rd, 32'h3);
		sci_host_model_inst.send_str("ATBD\015");
		expect_chars(sci_host_model_inst.reply_q, "0005\015");
		sci_host_model_inst.send_str("ATCC\015");
		expect_chars(sci_host_model_inst.reply_q, "002B\015");
		sci_host_model_inst.send_str("ATBD9\015");
		expect_chars(sci_host_model_inst.reply_q, "ERROR\015");
		sci_host_model_inst.send_str("XYBD\015");
		expect_chars(sci_host_model_inst.reply_q, "ERROR\015");
		sci_host_model_inst.send_str("ATGT5\015");
		expect_chars(sci_host_model_inst.reply_q, "OK\015");
		sci_host_model_inst.send_str("ATCT1\015");
		expect_chars(sci_host_model_inst.reply_q, "OK\015");
		sci_host_model_inst.send_str("ATAC\015");
		expect_chars(sci_host_model_inst.reply_q, "OK\015");
		check("baud applied", 32'(cfg_o[IDX_BAUD]), 32'h5);
		wb_xfer(1'b0, REG_STATUS, 32'h0, rd);
		check("status applied", rd, 32'h1);
		wb_xfer(1'b0, REG_GUARD, 32'h0, rd);
		check("guard reg", rd, 32'h5);
		wb_xfer(1'b0, REG_TMO, 32'h0, rd);
		check("tmo reg", rd, 32'h1);
		check("no payload", 32'(sci_host_model_inst.pay_q.size()),
			32'h0);
		sci_host_model_inst.send_str("ATCN\015");
		expect_chars(sci_host_model_inst.reply_q, "OK\015");
		wait_cmd(1'b0, 20);
		slow <= 1'b0;
		$display("test commands done");

		wb_xfer(1'b1, REG_CTRL, 32'h0, rd);
		repeat (60) @(posedge clk);
		sci_host_model_inst.send_str("+++");
		repeat (200) @(posedge clk);
		check("disabled", 32'(in_cmd), 32'h0);
		expect_chars(sci_host_model_inst.pay_q, "+++");
		wb_xfer(1'b1, REG_CTRL, 32'h1, rd);
		repeat (60) @(posedge clk);
		sci_host_model_inst.send_str("+++q");
		repeat (200) @(posedge clk);
		check("aborted", 32'(in_cmd), 32'h0);
		expect_chars(sci_host_model_inst.pay_q, "+++q");
		$display("test abort done");

		repeat (60) @(posedge clk);
		sci_host_model_inst.send_str("+++");
		wait_cmd(1'b1, 300);
		expect_chars(sci_host_model_inst.reply_q, "OK\015");
		sci_host_model_inst.send_str("ATWR\015");
		expect_chars(sci_host_model_inst.reply_q, "OK\015");
		sci_host_model_inst.send_str("ATBD2\015");
		expect_chars(sci_host_model_inst.reply_q, "OK\015");
		repeat (500) @(posedge clk);
		sci_host_model_inst.send_str("ATBD\015");
		expect_chars(sci_host_model_inst.reply_q, "0002\015");
		repeat (800) @(posedge clk);
		check("restarted", 32'(in_cmd), 32'h1);
		wait_cmd(1'b0, 400);
		check("baud on leave", 32'(cfg_o[IDX_BAUD]), 32'h2);
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		ce <= 1'b0;
		repeat (8) @(posedge clk);
		check("frozen load", 32'(cfg_o[IDX_BAUD]), 32'h3);
		ce <= 1'b1;
		repeat (8) @(posedge clk);
		check("baud saved", 32'(cfg_o[IDX_BAUD]), 32'h5);
		check("guard saved", 32'(cfg_o[IDX_GUARD]), 32'h5);
		check("tmo saved", 32'(cfg_o[IDX_TMO]), 32'h1);
		$display("test timeout and save done");
		finish_test();
	end

	// the run needs about 25000 cycles
	initial begin
		repeat (60000) @(posedge clk);
		err_total++;
		$display("watchdog expired");
		finish_test();
	end
endmodule // tb
